/* src/svd_defs.svh */
/*
 * Constants of the supply level detector control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 50 MHz system clock and a 256 Hz prescaler tap.
 */
`ifndef SVD_DEFS_SVH
`define SVD_DEFS_SVH

// Register byte offsets.
`define SVD_OFS_CONTROL   8'h00
`define SVD_OFS_THRESHOLD 8'h04
`define SVD_OFS_IRQ_STAT  8'h08
`define SVD_OFS_IRQ_MASK  8'h0c

// Control register field positions.
`define SVD_BIT_RESULT    3
`define SVD_BIT_START     2
`define SVD_BIT_BUSY      2
`define SVD_BIT_NO_OSC    1
`define SVD_BIT_NO_LOGIC  0

// Interrupt status and mask field positions.
`define SVD_IRQ_DONE      0
`define SVD_IRQ_REFUSED   1

// Reset values.
`define SVD_RST_CONTROL   4'h0
`define SVD_RST_THRESHOLD 3'h0
`define SVD_RST_IRQ       2'h0

// Timing figures.
`define SVD_SYS_HZ        50000000
`define SVD_TAP_HZ        256
`define SVD_RESULT_TAPS_X10 15
`define SVD_TAP_PERIOD_CYC (`SVD_SYS_HZ / `SVD_TAP_HZ)
`define SVD_RESULT_MAX_CYC ((`SVD_TAP_PERIOD_CYC * `SVD_RESULT_TAPS_X10) / 10)

`endif

/* src/svd_pkg.sv */
/*
 * Types of the supply level detector control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package svd_pkg;

	typedef enum logic [1:0] {
		SVD_IDLE,
		SVD_WAIT_RISE,
		SVD_MEASURE
	} svd_state_t;

	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] haddr;
		logic        hready;
		logic [31:0] hwdata;
	} svd_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} svd_ahb_rsp_t;

	typedef struct packed {
		logic result;
		logic busy;
		logic no_osc;
		logic no_logic;
	} svd_ctrl_t;

endpackage

/* src/svd_ctrl.sv */
/*
 * Supply level detector control: AHB-Lite register slave, start and busy
 * handling, measurement timed by the 256 Hz prescaler tap, result latch,
 * threshold decode and a masked interrupt.
 * Assumes the prescaler tap and comparator output arrive from outside the
 * clock domain, and that sleep_mode comes from logic on sys_clk.
 */
// Functional notes
// - No detection starts or runs during sleep.
// - Writing one to start begins a detection when idle; a start while busy is refused.
// - Measure from next tap rise while tap high.
// - Busy high from start write to measure end.
// - Result ready within 1.5 tap periods.
// - Result 0 above threshold, 1 below.
// - Code 000 highest level, 111 lowest level.
`include "svd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module svd_ctrl #(
	parameter int TAP_PERIOD_CYC = `SVD_TAP_PERIOD_CYC,
	parameter int RESULT_MAX_CYC = `SVD_RESULT_MAX_CYC
) (
	// Clock and reset.
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	// AHB-Lite slave.
	input  wire svd_pkg::svd_ahb_req_t ahb_req,
	output var  svd_pkg::svd_ahb_rsp_t ahb_rsp,
	// Prescaler, power and comparator.
	input  wire logic                  prescaler_tap_256hz,
	input  wire logic                  sleep_mode,
	input  wire logic                  supply_below,
	// Analog control.
	output logic                       detector_enable,
	output logic [7:0]                 level_select,
	// Supervisor controls.
	output logic                       disable_oscillator_supervisor,
	output logic                       disable_logic_supervisor,
	// Interrupt.
	output logic                       irq
);
	import svd_pkg::*;

	/************************************************************
	 * Input synchronisers
	 ************************************************************/
	logic tap_s1;
	logic tap_s2;
	logic tap_s3;
	logic cmp_s1;
	logic cmp_s2;

	always_ff @(posedge sys_clk) begin
		tap_s1 <= prescaler_tap_256hz;
		tap_s2 <= tap_s1;
		tap_s3 <= tap_s2;
		cmp_s1 <= supply_below;
		cmp_s2 <= cmp_s1;
	end

	// The third stage only delays the synchronised tap to form edge pulses.
	// Nothing but tap_s2 reads the first stage's output.
	wire tap_rise = tap_s2 & ~tap_s3;
	wire tap_fall = ~tap_s2 & tap_s3;

	/************************************************************
	 * Bus address and data phase
	 ************************************************************/
	logic       ap_write;
	logic [7:0] ap_addr;

	wire bus_take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
	wire rd_take  = bus_take & ~ahb_req.hwrite;
	wire wr_take  = bus_take & ahb_req.hwrite;
	wire [7:0] rd_addr = ahb_req.haddr[7:0];
	wire rd_hi_zero = (ahb_req.haddr[31:8] == 24'h000000);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ap_write <= 1'b0;
			ap_addr  <= 8'h00;
		end else begin
			ap_write <= wr_take & (ahb_req.haddr[31:8] == 24'h000000);
			ap_addr  <= ahb_req.haddr[7:0];
		end
	end

	wire wr_ctrl   = ap_write & (ap_addr == `SVD_OFS_CONTROL);
	wire wr_thr    = ap_write & (ap_addr == `SVD_OFS_THRESHOLD);
	wire wr_mask   = ap_write & (ap_addr == `SVD_OFS_IRQ_MASK);
	wire rd_ctrl   = rd_take & rd_hi_zero & (rd_addr == `SVD_OFS_CONTROL);
	wire rd_thr    = rd_take & rd_hi_zero & (rd_addr == `SVD_OFS_THRESHOLD);
	wire rd_stat   = rd_take & rd_hi_zero & (rd_addr == `SVD_OFS_IRQ_STAT);
	wire rd_mask   = rd_take & rd_hi_zero & (rd_addr == `SVD_OFS_IRQ_MASK);
	// Writes land in the data phase, when hwdata stands on the bus.
	// Reads are decoded in the address phase so hrdata is ready one cycle later.
	wire start_wr  = wr_ctrl & ahb_req.hwdata[`SVD_BIT_START];

	/************************************************************
	 * Control and threshold registers
	 ************************************************************/
	svd_ctrl_t  ctrl;
	logic [2:0] threshold;
	logic [1:0] irq_mask;
	logic [1:0] irq_stat;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl.no_osc   <= 1'(`SVD_RST_CONTROL >> `SVD_BIT_NO_OSC);
			ctrl.no_logic <= 1'b0;
			threshold     <= `SVD_RST_THRESHOLD;
			irq_mask      <= `SVD_RST_IRQ;
		end else begin
			if (wr_ctrl) begin
				ctrl.no_osc   <= ahb_req.hwdata[`SVD_BIT_NO_OSC];
				ctrl.no_logic <= ahb_req.hwdata[`SVD_BIT_NO_LOGIC];
			end
			if (wr_thr)
				threshold <= ahb_req.hwdata[2:0];
			if (wr_mask)
				irq_mask <= ahb_req.hwdata[1:0];
		end
	end

	/************************************************************
	 * Detection sequence
	 ************************************************************/
	svd_state_t state;
	svd_state_t next_state;

	wire start_ok  = start_wr & ~sleep_mode & (state == SVD_IDLE);
	wire start_bad = start_wr & ~start_ok;
	// Sleep aborts a run: busy drops, but no result is latched and no done flag is set.
	wire meas_end  = (state == SVD_MEASURE) & tap_fall & ~sleep_mode;

	always_comb begin
		next_state = state;
		if (sleep_mode) begin
			next_state = SVD_IDLE;
		end else begin
			unique case (state)
				SVD_IDLE:
					if (start_ok)
						next_state = SVD_WAIT_RISE;
				SVD_WAIT_RISE:
					if (tap_rise)
						next_state = SVD_MEASURE;
				SVD_MEASURE:
					if (tap_fall)
						next_state = SVD_IDLE;
				default:
					next_state = SVD_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state           <= SVD_IDLE;
			ctrl.busy       <= 1'b0;
			ctrl.result     <= 1'b0;
			detector_enable <= 1'b0;
		end else begin
			state           <= next_state;
			ctrl.busy       <= next_state != SVD_IDLE;
			detector_enable <= next_state == SVD_MEASURE;
			// The result is only ever replaced by a completed measurement.
			if (meas_end)
				ctrl.result <= cmp_s2;
		end
	end

	/************************************************************
	 * Threshold decode and supervisor controls
	 ************************************************************/
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			level_select                  <= 8'h01;
			disable_oscillator_supervisor <= 1'b0;
			disable_logic_supervisor      <= 1'b0;
		end else begin
			level_select                  <= 8'h01 << threshold;
			disable_oscillator_supervisor <= ctrl.no_osc;
			disable_logic_supervisor      <= ctrl.no_logic;
		end
	end

	/************************************************************
	 * Interrupt status, read clears, set wins
	 ************************************************************/
	// An event in the cycle of a clearing read survives, so no event is lost.
	wire [1:0] irq_set = {start_bad, meas_end};
	wire [1:0] next_irq_stat = (rd_stat ? 2'h0 : irq_stat) | irq_set;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			irq_stat <= `SVD_RST_IRQ;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	/************************************************************
	 * Read data
	 ************************************************************/
	// Unmapped offsets read as zero.
	wire [31:0] rd_data =
		rd_ctrl ? {28'h0000000, ctrl} :
		rd_thr  ? {29'h00000000, threshold} :
		rd_stat ? {30'h00000000, irq_stat} :
		rd_mask ? {30'h00000000, irq_mask} :
		32'h00000000;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ahb_rsp <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h00000000};
		end else begin
			ahb_rsp.hreadyout <= 1'b1;
			ahb_rsp.hresp     <= 1'b0;
			if (rd_take)
				ahb_rsp.hrdata <= rd_data;
		end
	end

	/************************************************************
	 * Checks
	 ************************************************************/
	logic [31:0] busy_cnt;

	always_ff @(posedge sys_clk) begin
		if (!reset_n || !ctrl.busy)
			busy_cnt <= 32'h00000000;
		else
			busy_cnt <= busy_cnt + 32'h00000001;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	AST_SLEEP_IDLE: assert property (sleep_mode |=> state == SVD_IDLE && !detector_enable)
		else $error("Detector active after sleep.");

	AST_START_BUSY: assert property (start_ok |=> ctrl.busy && state == SVD_WAIT_RISE)
		else $error("Start write did not raise busy.");

	AST_MEASURE_ON_RISE: assert property (state == SVD_WAIT_RISE && tap_rise && !sleep_mode |=> detector_enable)
		else $error("Measure did not start on tap rise.");

	AST_MEASURE_TAP_HIGH: assert property (detector_enable |-> $past(tap_s2))
		else $error("Measuring while tap low.");

	AST_BUSY_HOLD: assert property ($fell(ctrl.busy) |-> $past(meas_end) || $past(sleep_mode))
		else $error("Busy fell before measurement end.");

	AST_RESULT_TIME: assert property (busy_cnt <= RESULT_MAX_CYC)
		else $error("Result later than 1.5 tap periods.");

	AST_RESULT_VALUE: assert property (meas_end |=> ctrl.result == $past(cmp_s2) && !ctrl.busy)
		else $error("Result does not match comparator.");

	AST_LEVEL_DECODE: assert property ($onehot(level_select) and (threshold == 3'h0 |=> level_select[0]))
		else $error("Threshold decode wrong.");

	AST_RESULT_HOLD: assert property (!meas_end |=> $stable(ctrl.result))
		else $error("Result changed without measurement.");

	AST_RESET_CLEAR: assert property ($rose(reset_n) |-> threshold == 3'h0 && !ctrl.no_osc && !ctrl.busy)
		else $error("Reset left control fields set.");

	/************************************************************
	 * Further checks on flags, timing and decode
	 ************************************************************/
	// Counts the cycles of one measurement window, which must not outlast
	// the high half of the tap period.
	logic [31:0] meas_cnt;

	always_ff @(posedge sys_clk) begin
		if (!reset_n || !detector_enable) begin
			meas_cnt <= 32'h00000000;
		end else begin
			meas_cnt <= meas_cnt + 32'h00000001;
		end
	end

	// The slave never stretches a transfer and never reports an error.
	AST_BUS_OKAY: assert property (
		ahb_rsp.hreadyout && !ahb_rsp.hresp
	) else $error("Bus response not ready or not okay.");

	// A start written during sleep must leave the detector idle.
	AST_SLEEP_START_REFUSED: assert property (
		start_wr && sleep_mode |=> !ctrl.busy && state == SVD_IDLE
	) else $error("Start accepted during sleep.");

	// A refused start is recorded so software can see it was dropped.
	AST_REFUSED_FLAG: assert property (
		start_bad |=> irq_stat[`SVD_IRQ_REFUSED]
	) else $error("Refused start not flagged.");

	// Completion is recorded in the same cycle that busy drops.
	AST_DONE_FLAG: assert property (
		meas_end |=> irq_stat[`SVD_IRQ_DONE] && !ctrl.busy
	) else $error("Completion not flagged.");

	// With no pending event the interrupt line must be low.
	AST_IRQ_QUIET: assert property (
		irq_stat == 2'h0 |-> !irq
	) else $error("Interrupt high without pending event.");

	// The analog detector is only powered during the measurement window.
	AST_ENABLE_IN_MEASURE: assert property (
		detector_enable |-> state == SVD_MEASURE
	) else $error("Detector enabled outside measurement.");

	// A window longer than the tap high phase means a missed tap fall.
	AST_MEASURE_LENGTH: assert property (
		meas_cnt <= TAP_PERIOD_CYC / 2 + 1
	) else $error("Measurement window too long.");

	// The lowest level code selects the last decode output.
	AST_LEVEL_LOWEST: assert property (
		threshold == 3'h7 |=> level_select[7]
	) else $error("Lowest level decode wrong.");

	// Supervisor outputs follow the written control bit two cycles later.
	AST_SUPERVISOR_COPY: assert property (
		wr_ctrl |=> ##1 disable_oscillator_supervisor == $past(ahb_req.hwdata[`SVD_BIT_NO_OSC], 2)
	) else $error("Supervisor output does not follow control.");

	// While waiting for the tap rise the block is busy but not measuring.
	AST_WAIT_BUSY: assert property (
		state == SVD_WAIT_RISE |-> ctrl.busy && !detector_enable
	) else $error("Wait state busy or enable wrong.");

endmodule

`default_nettype wire

/* dv/svd_ctrl_tb.sv */
/*
 * Self-checking bench of the supply level detector control block.
 * Assumes svd_pkg and svd_defs.svh are compiled first; the tap is shortened.
 */
`include "svd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module svd_ctrl_tb;
	import svd_pkg::*;
	localparam int TAP = 64;
	logic         sys_clk = 1'b0;
	logic         reset_n = 1'b0;
	svd_ahb_req_t ahb_req = '0;
	svd_ahb_rsp_t ahb_rsp;
	logic         tap = 1'b0;
	logic         sleep_mode = 1'b0;
	logic         supply_below = 1'b0;
	logic         detector_enable;
	logic [7:0]   level_select;
	logic         no_osc;
	logic         no_logic;
	logic         irq;
	int           bad_count = 0;
	int           checks_done = 0;
	int           seed = 32'h539aa570;
	int           cyc = 0;
	int           en_cnt = 0;
	int           t0;
	int           e0;
	logic [31:0]  rd;
	logic [2:0]   code;

	svd_ctrl #(.TAP_PERIOD_CYC(TAP), .RESULT_MAX_CYC(TAP * 3 / 2)) i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
		.prescaler_tap_256hz(tap), .sleep_mode(sleep_mode), .supply_below(supply_below),
		.detector_enable(detector_enable), .level_select(level_select),
		.disable_oscillator_supervisor(no_osc), .disable_logic_supervisor(no_logic), .irq(irq));

	// ***************************************************************
	// Clock, fast prescaler tap and enable-cycle counter.
	// ***************************************************************
	always #10 sys_clk = ~sys_clk;
	always @* ahb_req.hready = ahb_rsp.hreadyout;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		tap <= (cyc % TAP) >= (TAP / 2);
		en_cnt <= en_cnt + int'(detector_enable);
	end

	// ***************************************************************
	// Bus tasks and comparison.
	// ***************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge sys_clk);
		ahb_req.hsel <= 1'b1;
		ahb_req.htrans <= 2'b10;
		ahb_req.hwrite <= wr;
		ahb_req.hsize <= 3'b010;
		ahb_req.haddr <= {24'h0, a};
		do @(posedge sys_clk); while (ahb_rsp.hreadyout !== 1'b1);
		ahb_req.htrans <= 2'b00;
		ahb_req.hwdata <= wr ? wd : 32'h0;
		do @(posedge sys_clk); while (ahb_rsp.hreadyout !== 1'b1);
		d = ahb_rsp.hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		bus(1'b1, a, v, x);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		check(rd, exp);
		check({31'h0, ahb_rsp.hresp}, 32'h0);
	endtask

	// Starts a run and polls until busy drops, with a bounded number of reads.
	task automatic start_and_wait(input logic twice);
		wr(`SVD_OFS_CONTROL, 32'h4);
		t0 = cyc;
		e0 = en_cnt;
		if (twice) wr(`SVD_OFS_CONTROL, 32'h4);
		bus(1'b0, `SVD_OFS_CONTROL, 32'h0, rd);
		check(rd & 32'h7, 32'h4);
		for (int i = 0; i < 200 && rd[2] !== 1'b0; i++) bus(1'b0, `SVD_OFS_CONTROL, 32'h0, rd);
		check(32'((cyc - t0) <= TAP * 3 / 2 + 12), 32'h1);
		check(32'((en_cnt - e0) >= TAP / 2 - 2 && (en_cnt - e0) <= TAP / 2 + 2), 32'h1);
	endtask

	task automatic detect(input logic bl);
		wr(`SVD_OFS_THRESHOLD, {29'h0, code});
		repeat (2) @(posedge sys_clk);
		check({24'h0, level_select}, 32'h1 << code);
		supply_below <= bl;
		repeat (3'($random(seed)) * 9) @(posedge sys_clk);
		start_and_wait(1'b0);
		check(rd, {28'h0, bl, 3'b000});
		check({31'h0, irq}, 32'h1);
		rdc(`SVD_OFS_IRQ_STAT, 32'h1);
		supply_below <= ~bl;
		repeat (2 * TAP) @(posedge sys_clk);
		check({31'h0, irq}, 32'h0);
		rdc(`SVD_OFS_CONTROL, {28'h0, bl, 3'b000});
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ***************************************************************
	// Main sequence and watchdog.
	// ***************************************************************
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		check({24'h0, level_select}, 32'h1);
		rdc(`SVD_OFS_CONTROL, 32'h0);
		rdc(`SVD_OFS_THRESHOLD, 32'h0);
		rdc(`SVD_OFS_IRQ_STAT, 32'h0);
		rdc(`SVD_OFS_IRQ_MASK, 32'h0);
		rdc(8'h40, 32'h0);
		for (int k = 0; k < 8; k++) begin
			wr(`SVD_OFS_THRESHOLD, 32'(k) | 32'hf8);
			rdc(`SVD_OFS_THRESHOLD, 32'(k));
			check({24'h0, level_select}, 32'h1 << k);
		end
		wr(`SVD_OFS_CONTROL, 32'h3);
		rdc(`SVD_OFS_CONTROL, 32'h3);
		check({30'h0, no_osc, no_logic}, 32'h3);
		wr(`SVD_OFS_CONTROL, 32'h0);
		wr(`SVD_OFS_IRQ_MASK, 32'h1);
		rdc(`SVD_OFS_IRQ_MASK, 32'h1);
		code = 3'h7;
		detect(1'b1);
		code = 3'h0;
		detect(1'b0);
		repeat (6) begin
			code = 3'($random(seed));
			detect(1'($random(seed)));
		end
		start_and_wait(1'b1);
		rdc(`SVD_OFS_IRQ_STAT, 32'h3);
		@(posedge sys_clk);
		sleep_mode <= 1'b1;
		e0 = en_cnt;
		wr(`SVD_OFS_CONTROL, 32'h4);
		repeat (2 * TAP) @(posedge sys_clk);
		check(32'(en_cnt - e0), 32'h0);
		check({31'h0, irq}, 32'h0);
		rdc(`SVD_OFS_IRQ_STAT, 32'h2);
		bus(1'b0, `SVD_OFS_CONTROL, 32'h0, rd);
		check(rd & 32'h7, 32'h0);
		sleep_mode <= 1'b0;
		wr(`SVD_OFS_CONTROL, 32'h4);
		for (int i = 0; i < 3 * TAP && detector_enable !== 1'b1; i++) @(posedge sys_clk);
		sleep_mode <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check({31'h0, detector_enable}, 32'h0);
		rdc(`SVD_OFS_CONTROL, rd & 32'h8);
		rdc(`SVD_OFS_IRQ_STAT, 32'h0);
		finish_test;
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count++;
		finish_test;
	end
endmodule

`default_nettype wire
